// ===== verilog/ogcr_pkg.sv
// package: register map, field layout, gain constants and carriers
package ogcr_pkg;
  // -------------------------------------------------
  // page selects and register offsets
  // -------------------------------------------------
  localparam logic [23:0] PAGE_OFFS_B = 24'h610000; // offset corrector, channel b
  localparam logic [23:0] PAGE_GAIN_A = 24'h610005; // digital gain, channel a
  localparam logic [23:0] PAGE_GAIN_B = 24'h610105; // digital gain, channel b
  localparam logic [23:0] PAGE_MAIN_A = 24'h680000; // main digital, channel a
  localparam logic [11:0] OFS_CORE    = 12'h000;    // core_reset_control
  localparam logic [11:0] OFS_OFFS    = 12'h068;    // offset_corrector_control_b
  localparam logic [11:0] OFS_GAIN    = 12'h0a6;    // digital_gain_control
  // -------------------------------------------------
  // field positions and masks
  // -------------------------------------------------
  localparam int FRZ_HI  = 7;                       // freeze code msb
  localparam int FRZ_MID = 5;                       // freeze code middle bit
  localparam int FRZ_LO  = 1;                       // freeze code lsb
  localparam int BYP_BIT = 2;                       // spur_cancel_bypass
  localparam int RST_BIT = 0;                       // global_core_reset
  localparam logic [7:0] OFFS_MASK = 8'he7;         // storable bits of offset reg
  localparam logic [7:0] OFFS_RST  = 8'h00;         // offset reg reset value
  localparam logic [3:0] GAIN_RST  = 4'h0;          // gain reset value, 0 db
  localparam logic [2:0] FRZ_HOLD  = 3'h7;          // code 111 freezes estimator
  localparam logic [3:0] GAIN_MAX  = 4'hb;          // 11 db, highest legal code
  localparam int GAIN_FRAC = 10;                    // gain table fraction bits
  localparam int EST_SHIFT = 8;                     // estimator averaging shift
  localparam int PHASES    = 8;                     // fs/8 interleave phases
  // -------------------------------------------------
  // carriers
  // -------------------------------------------------
  typedef struct packed {
    logic [23:0] page;                              // configuration page
    logic [11:0] addr;                              // register offset
    logic [7:0]  wdata;                             // write data
    logic        wr;                                // write strobe
    logic        rd;                                // read strobe
  } ogcr_req_t;
  typedef struct packed {
    logic       en;                                 // zone specification enable
    logic [2:0] zone;                               // nyquist zone code
  } ogcr_nyq_t;
endpackage

// ===== verilog/ogcr_top.sv
// offset corrector control for channel b, digital gain and global core reset for two channels
// Function
// RULE1 - freeze code is bits 7,5,1, msb first
// RULE2 - software programs freeze code 011 after power-up
// RULE3 - code 111 holds last offset estimate
// RULE4 - software writes ones to bits 6, 1
// RULE5 - bypass clear: cancel interleave offset spurs
// RULE6 - bypass set: samples pass uncorrected
// RULE7 - four-bit gain applied before down-conversion
// RULE8 - gain one db per code, 0 to 11
// RULE9 - gain register per channel page
// RULE10 - reset bit pulse resets both channels
// RULE11 - nyquist settings apply on reset pulse
// RULE12 - core reset on channel-a main page
// RULE13 - software writes zero to unnamed bits
`timescale 1ns/10ps
module ogcr_top #(
  parameter int DW = 14                              // sample width
) (
  input  wire logic                 clk_in,          // 25 mhz device clock
  input  wire logic                 nrst_in,         // async power-on reset
  input  wire ogcr_pkg::ogcr_req_t  req_in,          // register request
  output logic [7:0]                rdata_out,       // read data, cycle after rd
  input  wire logic signed [DW-1:0] samp_a_in,       // converter samples, chan a
  input  wire logic signed [DW-1:0] samp_b_in,       // converter samples, chan b
  input  wire ogcr_pkg::ogcr_nyq_t  nyq_a_in,        // programmed zone, chan a
  input  wire ogcr_pkg::ogcr_nyq_t  nyq_b_in,        // programmed zone, chan b
  output logic signed [DW-1:0]      data_a_out,      // gained samples, chan a
  output logic signed [DW-1:0]      data_b_out,      // corrected, gained, chan b
  output ogcr_pkg::ogcr_nyq_t       nyq_a_out,       // active zone, chan a
  output ogcr_pkg::ogcr_nyq_t       nyq_b_out,       // active zone, chan b
  output logic                      core_rst_out     // digital core reset, both
);
  // -------------------------------------------------
  // register file
  // -------------------------------------------------
  logic [7:0]  offs_r;                               // offset_corrector_control_b
  logic [3:0]  gain_a_r;                             // digital_gain_control, a
  logic [3:0]  gain_b_r;                             // digital_gain_control, b
  logic        rst_bit_r;                            // global_core_reset bit
  logic        rst_q_r;                              // reset bit, one cycle late
  logic [7:0]  rdata_r;                              // registered read data
  logic        hit_offs, hit_ga, hit_gb, hit_core;   // address decode

  // decode; a page mismatch reaches no register
  assign hit_offs = req_in.page == ogcr_pkg::PAGE_OFFS_B && req_in.addr == ogcr_pkg::OFS_OFFS;
  assign hit_ga   = req_in.page == ogcr_pkg::PAGE_GAIN_A && req_in.addr == ogcr_pkg::OFS_GAIN;
  assign hit_gb   = req_in.page == ogcr_pkg::PAGE_GAIN_B && req_in.addr == ogcr_pkg::OFS_GAIN;
  assign hit_core = req_in.page == ogcr_pkg::PAGE_MAIN_A && req_in.addr == ogcr_pkg::OFS_CORE; // [RULE12]

  // offset control; must-write-0 bits 4 and 3 are not stored
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      offs_r <= ogcr_pkg::OFFS_RST;
    else if (req_in.wr && hit_offs)
      offs_r <= req_in.wdata & ogcr_pkg::OFFS_MASK;
  end

  // gain per channel page [RULE9]
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      gain_a_r <= ogcr_pkg::GAIN_RST;
      gain_b_r <= ogcr_pkg::GAIN_RST;
    end
    else
    begin
      if (req_in.wr && hit_ga)
        gain_a_r <= req_in.wdata[3:0];
      if (req_in.wr && hit_gb)
        gain_b_r <= req_in.wdata[3:0];
    end
  end

  // core reset bit; software writes it high then low [RULE10]
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_bit_r <= 1'b0;
      rst_q_r   <= 1'b0;
    end
    else
    begin
      if (req_in.wr && hit_core)
        rst_bit_r <= req_in.wdata[ogcr_pkg::RST_BIT];
      rst_q_r <= rst_bit_r;
    end
  end

  // read port; unmapped addresses answer zero
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_r <= 8'h00;
    else if (req_in.rd)
    begin
      if (hit_offs)
        rdata_r <= offs_r;
      else if (hit_ga)
        rdata_r <= {4'h0, gain_a_r};
      else if (hit_gb)
        rdata_r <= {4'h0, gain_b_r};
      else if (hit_core)
        rdata_r <= {7'h00, rst_bit_r};
      else
        rdata_r <= 8'h00;
    end
  end
  assign rdata_out    = rdata_r;
  assign core_rst_out = rst_bit_r;                   // one reset for both channels [RULE10]

  // -------------------------------------------------
  // nyquist zone staging
  // -------------------------------------------------
  logic       apply_nyq;                             // falling edge of reset bit
  ogcr_pkg::ogcr_nyq_t nyq_a_r, nyq_b_r;             // active zone settings

  assign apply_nyq = rst_q_r && !rst_bit_r;

  // zone inputs stay parked until the pulse ends, then both load at once
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      nyq_a_r <= '0;
      nyq_b_r <= '0;
    end
    else if (apply_nyq)                              // [RULE11]
    begin
      nyq_a_r <= nyq_a_in;
      nyq_b_r <= nyq_b_in;
    end
  end
  assign nyq_a_out = nyq_a_r;
  assign nyq_b_out = nyq_b_r;

  // -------------------------------------------------
  // offset corrector, channel b
  // -------------------------------------------------
  logic [2:0]          frz_code;                     // freeze code
  logic                frozen;                       // estimator held
  logic                bypass;                       // spur_cancel_bypass
  logic [2:0]          phase_r;                      // interleave phase
  logic signed [DW+7:0] est_r [ogcr_pkg::PHASES];    // per-phase estimate, 8 frac bits
  logic signed [DW+7:0] err;                         // sample minus estimate
  logic signed [DW-1:0] est_int;                     // integer part of estimate
  logic signed [DW:0]   diff;                        // corrected sample, wide
  logic signed [DW-1:0] corr_b_r;                    // corrected sample, chan b
  logic signed [DW-1:0] samp_a_r;                    // aligned sample, chan a

  assign frz_code = {offs_r[ogcr_pkg::FRZ_HI], offs_r[ogcr_pkg::FRZ_MID],
                     offs_r[ogcr_pkg::FRZ_LO]};      // msb is bit 7 [RULE1]
  assign frozen   = frz_code == ogcr_pkg::FRZ_HOLD;  // [RULE3]
  assign bypass   = offs_r[ogcr_pkg::BYP_BIT];
  assign est_int  = est_r[phase_r][DW+7:8];
  assign err      = {samp_b_in, 8'h00} - est_r[phase_r];
  assign diff     = {samp_b_in[DW-1], samp_b_in} - {est_int[DW-1], est_int};

  // phase counter: spurs at k*fs/8 come from eight interleaved offsets
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      phase_r <= 3'h0;
    else if (rst_bit_r)
      phase_r <= 3'h0;
    else
      phase_r <= phase_r + 3'h1;
  end

  // leaky average per phase; frozen keeps applying the last value
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < ogcr_pkg::PHASES; i++)
        est_r[i] <= '0;
    end
    else if (rst_bit_r)
    begin
      for (int i = 0; i < ogcr_pkg::PHASES; i++)
        est_r[i] <= '0;
    end
    else if (!frozen && !bypass)                     // [RULE3]
      est_r[phase_r] <= est_r[phase_r] + (err >>> ogcr_pkg::EST_SHIFT);
  end

  // subtract estimate, or pass straight through when bypassed
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      corr_b_r <= '0;
      samp_a_r <= '0;
    end
    else if (rst_bit_r)
    begin
      corr_b_r <= '0;
      samp_a_r <= '0;
    end
    else
    begin
      samp_a_r <= samp_a_in;
      if (bypass)
        corr_b_r <= samp_b_in;                       // [RULE6]
      else if (diff > $signed({2'b00, {(DW-1){1'b1}}}))
        corr_b_r <= {1'b0, {(DW-1){1'b1}}};          // clip high [RULE5]
      else if (diff < $signed({2'b11, {(DW-1){1'b0}}}))
        corr_b_r <= {1'b1, {(DW-1){1'b0}}};          // clip low [RULE5]
      else
        corr_b_r <= diff[DW-1:0];                    // [RULE5]
    end
  end

  // -------------------------------------------------
  // digital gain, ahead of the down-converters
  // -------------------------------------------------
  // linear factor 10^(db/20) in q2.10; illegal codes clamp to 11 db
  function automatic logic signed [12:0] gain_lin(input logic [3:0] code);
    logic [3:0] c;
    c = (code > ogcr_pkg::GAIN_MAX) ? ogcr_pkg::GAIN_MAX : code;
    case (c)
      4'h0:    gain_lin = 13'sh0400;
      4'h1:    gain_lin = 13'sh047d;
      4'h2:    gain_lin = 13'sh0509;
      4'h3:    gain_lin = 13'sh05a6;
      4'h4:    gain_lin = 13'sh0657;
      4'h5:    gain_lin = 13'sh071d;
      4'h6:    gain_lin = 13'sh07fb;
      4'h7:    gain_lin = 13'sh08f4;
      4'h8:    gain_lin = 13'sh0a0c;
      4'h9:    gain_lin = 13'sh0b46;
      4'ha:    gain_lin = 13'sh0ca6;
      default: gain_lin = 13'sh0e31;
    endcase
  endfunction

  // scale and saturate to sample width
  function automatic logic signed [DW-1:0] scale(input logic signed [DW-1:0] x,
                                                 input logic [3:0] code);
    logic signed [DW+12:0] p;
    logic signed [DW+2:0]  s;
    p = x * gain_lin(code);
    s = p[DW+12:ogcr_pkg::GAIN_FRAC];
    if (s > $signed({4'h0, {(DW-1){1'b1}}}))
      scale = {1'b0, {(DW-1){1'b1}}};
    else if (s < $signed({4'hf, {(DW-1){1'b0}}}))
      scale = {1'b1, {(DW-1){1'b0}}};
    else
      scale = s[DW-1:0];
  endfunction

  // gain stage registers; held at zero through core reset
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      data_a_out <= '0;
      data_b_out <= '0;
    end
    else if (rst_bit_r)
    begin
      data_a_out <= '0;
      data_b_out <= '0;
    end
    else
    begin
      data_a_out <= scale(samp_a_r, gain_a_r);       // [RULE7] [RULE8]
      data_b_out <= scale(corr_b_r, gain_b_r);       // [RULE7] [RULE8]
    end
  end

  // -------------------------------------------------
  // assertions
  // -------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  property p_frz_code;
    req_in.wr && hit_offs && req_in.wdata == 8'he2 |=> frozen && bypass == 1'b0;
  endproperty
  a_frz_code: assert property (p_frz_code) else $error("freeze code not formed"); // [RULE1]

  property p_frz_hold;
    frozen && !rst_bit_r |=> est_r[phase_r - 3'h1] == $past(est_r[phase_r]);
  endproperty
  a_frz_hold: assert property (p_frz_hold) else $error("estimate moved while frozen"); // [RULE3]

  property p_cancel;
    !bypass && !rst_bit_r && diff == $signed({1'b0, diff[DW-1:0]}) && !diff[DW-1]
      |=> corr_b_r == $past(diff[DW-1:0]);
  endproperty
  a_cancel: assert property (p_cancel) else $error("offset not removed"); // [RULE5]

  property p_bypass;
    bypass && !rst_bit_r |=> corr_b_r == $past(samp_b_in);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass altered sample"); // [RULE6]

  property p_unity;
    gain_b_r == 4'h0 && !rst_bit_r ##1 gain_b_r == 4'h0 && !rst_bit_r |=> data_b_out == $past(corr_b_r);
  endproperty
  a_unity: assert property (p_unity) else $error("zero code not unity gain"); // [RULE8]

  property p_gain_up;
    gain_a_r == 4'h6 && !rst_bit_r && samp_a_r == 14'sh03e8 |=> data_a_out == 14'sh07cb;
  endproperty
  a_gain_up: assert property (p_gain_up) else $error("6 db gain wrong"); // [RULE7]

  property p_gain_rd;
    req_in.rd && hit_gb |=> rdata_out == {4'h0, $past(gain_b_r)};
  endproperty
  a_gain_rd: assert property (p_gain_rd) else $error("channel b gain readback"); // [RULE9]

  property p_core;
    req_in.wr && hit_core && req_in.wdata[0] |=> core_rst_out ##1 data_a_out == '0 && data_b_out == '0;
  endproperty
  a_core: assert property (p_core) else $error("core reset not on both"); // [RULE10]

  property p_nyq;
    rst_bit_r ##1 !rst_bit_r |=> nyq_a_out == $past(nyq_a_in) && nyq_b_out == $past(nyq_b_in);
  endproperty
  a_nyq: assert property (p_nyq) else $error("zone not applied on pulse"); // [RULE11]

  property p_nyq_hold;
    !apply_nyq |=> $stable(nyq_a_out) && $stable(nyq_b_out);
  endproperty
  a_nyq_hold: assert property (p_nyq_hold) else $error("zone changed early"); // [RULE11]

  property p_page;
    req_in.wr && req_in.addr == ogcr_pkg::OFS_CORE && req_in.page != ogcr_pkg::PAGE_MAIN_A
      |=> $stable(core_rst_out);
  endproperty
  a_page: assert property (p_page) else $error("core reset on wrong page"); // [RULE12]

  c_freeze: cover property (!frozen ##1 frozen);
  c_pulse:  cover property (rst_bit_r ##1 !rst_bit_r);
  c_bypass: cover property (bypass && !rst_bit_r ##3 !bypass);
  c_gain11: cover property (gain_b_r == ogcr_pkg::GAIN_MAX && !rst_bit_r);
endmodule // ogcr_top

// ===== sim/tb_top.sv
// self-checking bench for the offset, gain and core reset register block
`timescale 1ns/10ps
module tb_top;
  // -------------------------------------------------
  // signals
  // -------------------------------------------------
  logic                   clk_in;       // 25 mhz clock
  logic                   nrst_in;      // async reset, active low
  ogcr_pkg::ogcr_req_t    req_in;       // register request
  logic [7:0]             rdata_out;    // read data
  logic signed [13:0]     samp_a_in;    // samples, chan a
  logic signed [13:0]     samp_b_in;    // samples, chan b
  ogcr_pkg::ogcr_nyq_t    nyq_a_in;     // programmed zone a
  ogcr_pkg::ogcr_nyq_t    nyq_b_in;     // programmed zone b
  logic signed [13:0]     data_a_out;   // output chan a
  logic signed [13:0]     data_b_out;   // output chan b
  ogcr_pkg::ogcr_nyq_t    nyq_a_out;    // active zone a
  ogcr_pkg::ogcr_nyq_t    nyq_b_out;    // active zone b
  logic                   core_rst_out; // core reset level
  int                     n_mismatch;   // mismatches seen
  int                     num_checks;   // comparisons made
  int                     cyc;          // cycles since start
  ogcr_top #(.DW(14)) ogcr_top_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .req_in(req_in), .rdata_out(rdata_out),
    .samp_a_in(samp_a_in), .samp_b_in(samp_b_in), .nyq_a_in(nyq_a_in), .nyq_b_in(nyq_b_in),
    .data_a_out(data_a_out), .data_b_out(data_b_out), .nyq_a_out(nyq_a_out),
    .nyq_b_out(nyq_b_out), .core_rst_out(core_rst_out)
  );
  // -------------------------------------------------
  // clock and timeout
  // -------------------------------------------------
  initial
  begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // ceiling well above the ~20.3k cycles the scenarios need
  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  // -------------------------------------------------
  // shared tasks
  // -------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] expd);
    num_checks = num_checks + 1;
    if (seen !== expd)
    begin
      n_mismatch = n_mismatch + 1;
      $display("Error at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask
  // write strobe for one cycle, released after the taking edge
  task automatic wr(input logic [23:0] pg, input logic [11:0] ad, input logic [7:0] d);
    @(posedge clk_in);
    req_in.page <= pg;
    req_in.addr <= ad;
    req_in.wdata <= d;
    req_in.wr <= 1'b1;
    @(posedge clk_in);
    req_in.wr <= 1'b0;
  endtask
  // read strobe; data is registered at the taking edge and holds until the next read
  task automatic rd(input logic [23:0] pg, input logic [11:0] ad, output logic [7:0] d);
    @(posedge clk_in);
    req_in.page <= pg;
    req_in.addr <= ad;
    req_in.rd <= 1'b1;
    @(posedge clk_in);
    req_in.rd <= 1'b0;
    #1 d = rdata_out;
  endtask
  // is x within tol of e
  function automatic logic near(input int x, input int e, input int tol);
    return (x >= e - tol) && (x <= e + tol);
  endfunction
  // -------------------------------------------------
  // scenarios
  // -------------------------------------------------
  task automatic t_reset_values();
    logic [7:0] d;
    rd(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, d); check(16'(d), 16'h0000);
    rd(ogcr_pkg::PAGE_GAIN_A, ogcr_pkg::OFS_GAIN, d); check(16'(d), 16'h0000);
    rd(ogcr_pkg::PAGE_MAIN_A, ogcr_pkg::OFS_CORE, d); check(16'(d), 16'h0000);
    rd(24'h123456, 12'h068, d); check(16'(d), 16'h0000);
  endtask
  // offset readback, channel separation of gain, foreign-page writes
  task automatic t_regs();
    logic [7:0] d;
    // first offset write after power-up: estimate code 011, must-one bits set
    wr(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, 8'h62);
    rd(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, d); check(16'(d), 16'h0062);
    wr(ogcr_pkg::PAGE_GAIN_A, ogcr_pkg::OFS_GAIN, 8'h05);
    wr(24'h123456, ogcr_pkg::OFS_GAIN, 8'h07);
    rd(ogcr_pkg::PAGE_GAIN_A, ogcr_pkg::OFS_GAIN, d); check(16'(d), 16'h0005);
    rd(ogcr_pkg::PAGE_GAIN_B, ogcr_pkg::OFS_GAIN, d); check(16'(d), 16'h0000);
    // reset bit written on a foreign page must not reach the core
    wr(24'h123456, ogcr_pkg::OFS_CORE, 8'h01);
    rd(ogcr_pkg::PAGE_MAIN_A, ogcr_pkg::OFS_CORE, d); check(16'(d), 16'h0000);
  endtask
  // every legal gain code on channel a, one on channel b
  task automatic t_gain();
    int e;
    wr(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, 8'h66);
    samp_a_in <= 14'sd1000;
    samp_b_in <= 14'sd1000;
    // only the legal codes 0 to 11 are driven
    for (int c = 0; c < 12; c++)
    begin
      wr(ogcr_pkg::PAGE_GAIN_A, ogcr_pkg::OFS_GAIN, 8'(c));
      repeat (4) @(posedge clk_in);
      #1 e = int'(1000.0 * (10.0 ** (((c > 11) ? 11 : c) / 20.0)));
      check(16'(near(int'(data_a_out), e, (c == 0) ? 0 : 4)), 16'h0001);
    end
    wr(ogcr_pkg::PAGE_GAIN_B, ogcr_pkg::OFS_GAIN, 8'h06);
    repeat (4) @(posedge clk_in);
    #1 check(16'(near(int'(data_b_out), 1995, 4)), 16'h0001);
    wr(ogcr_pkg::PAGE_GAIN_A, ogcr_pkg::OFS_GAIN, 8'h00);
    wr(ogcr_pkg::PAGE_GAIN_B, ogcr_pkg::OFS_GAIN, 8'h00);
  endtask
  // estimation, freeze at code 111, then bypass
  task automatic t_offset();
    wr(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, 8'h62);
    samp_b_in <= 14'sd1000;
    // long settle: leaky average needs thousands of cycles per phase
    repeat (20000) @(posedge clk_in);
    #1 check(16'(near(int'(data_b_out), 0, 16)), 16'h0001);
    wr(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, 8'he2);
    samp_b_in <= 14'sd1500;
    repeat (200) @(posedge clk_in);
    #1 check(16'(near(int'(data_b_out), 500, 16)), 16'h0001);
    wr(ogcr_pkg::PAGE_OFFS_B, ogcr_pkg::OFS_OFFS, 8'h66);
    repeat (4) @(posedge clk_in);
    #1 check(16'(data_b_out), 16'(14'sd1500));
  endtask
  // core reset pulse holds both channels and applies zones
  task automatic t_core_reset();
    logic [7:0] d;
    nyq_a_in <= 4'ha;
    nyq_b_in <= 4'hd;
    repeat (3) @(posedge clk_in);
    #1 check(16'({nyq_a_out, nyq_b_out}), 16'h0000);
    wr(ogcr_pkg::PAGE_MAIN_A, ogcr_pkg::OFS_CORE, 8'h01);
    repeat (3) @(posedge clk_in);
    #1 check(16'({core_rst_out, data_a_out}), 16'h4000);
    check(16'(data_b_out), 16'h0000);
    rd(ogcr_pkg::PAGE_MAIN_A, ogcr_pkg::OFS_CORE, d); check(16'(d), 16'h0001);
    wr(ogcr_pkg::PAGE_MAIN_A, ogcr_pkg::OFS_CORE, 8'h00);
    @(posedge clk_in);
    #1 check(16'({nyq_a_out, nyq_b_out}), 16'h00ad);
    check(16'(core_rst_out), 16'h0000);
  endtask
  // -------------------------------------------------
  // verdict
  // -------------------------------------------------
  task automatic summarize();
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // -------------------------------------------------
  // main sequence
  // -------------------------------------------------
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    nrst_in = 1'b0;
    req_in = '0;
    samp_a_in = '0;
    samp_b_in = '0;
    nyq_a_in = '0;
    nyq_b_in = '0;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_reset_values();
    t_regs();
    t_gain();
    t_offset();
    t_core_reset();
    summarize();
  end
endmodule // tb_top
